// ===== design/tms_pkg.sv
// How it works
// - masked control write changes only selected run bits
// - all-ones sets every run; mask zero no change
// - run bit shows counting; masked write starts/stops
// - mask bit n steers run bit n plus four
// - stop-on-receive halts timer0 after four bits
// - stop-on-receive ignored during oscillator trimming
// - mode 00 no autostart; 01 start at transmit end
// - modes 10/11 trimming, start/stop on oscillator edges
// - auto reload reloads and continues at zero, except mode 10 holds at zero
// - without auto reload, stop at zero, except mode 10 holds at zero and keeps running
// - every underflow sets the interrupt flag
// - clock select 00 fast, 01 slow clock
// - clock select 10 timer2, 11 timer1 underflow
// - start event loads counter from reload bytes
// - reload writes wait for next start event or auto reload
// - count readable as separate high, low bytes
package tms_pkg;

    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_TSEC_CTRL    = 6'h0e;
    localparam logic [5:0] IDX_T0_CTRL      = 6'h0f;
    localparam logic [5:0] IDX_T0_RELOAD_HI = 6'h10;
    localparam logic [5:0] IDX_T0_RELOAD_LO = 6'h11;
    localparam logic [5:0] IDX_T0_COUNT_HI  = 6'h12;
    localparam logic [5:0] IDX_T0_COUNT_LO  = 6'h13;
    localparam logic [5:0] IDX_IRQ_STATUS   = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK     = 6'h21;

    // control field positions
    localparam int RUN_LSB       = 4;
    localparam int T0_STOP_RX    = 7;
    localparam int T0_MODE_LSB   = 4;
    localparam int T0_AUTO       = 3;
    localparam int T0_CLK_LSB    = 0;
    localparam logic [7:0] T0_CTRL_WMASK = 8'hbb;

    // reset values
    localparam logic [7:0]  T0_CTRL_RST = 8'h00;
    localparam logic [7:0]  RELOAD_RST  = 8'h00;
    localparam logic [15:0] COUNT_RST   = 16'h0000;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // count clock rates
    localparam longint SYS_HZ  = 200000000;
    localparam longint FAST_HZ = 13560000;
    localparam longint SLOW_HZ = 211875;
    localparam int FAST_DIV = int'(SYS_HZ / FAST_HZ);
    localparam int SLOW_DIV = int'(SYS_HZ / SLOW_HZ);

    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_TX_END,
        MODE_TRIM_HOLD,
        MODE_TRIM_WRAP
    } tms_mode_t;

    typedef enum logic [1:0] {
        CLK_FAST,
        CLK_SLOW,
        CLK_TIMER2,
        CLK_TIMER1
    } tms_clk_t;

endpackage

// ===== design/tms_timer_section.sv
`timescale 1ns/100ps
module tms_timer_section #(
    parameter int AW = 8
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // axi4-lite write address
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]    s_axi_awprot,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    // axi4-lite write response
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // axi4-lite read address
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic [2:0]    s_axi_arprot,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    // axi4-lite read data
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // transceiver and oscillator events
    input  wire logic          tx_end,
    input  wire logic          rx_first_bits,
    input  wire logic          lfo_posedge,
    // other timers
    input  wire logic          timer1_underflow,
    input  wire logic          timer2_underflow,
    input  wire logic [3:1]    timer_stopped,
    output logic [3:1]         timer_run_flag,
    // timer0 results
    output logic               timer0_underflow,
    output logic               irq
);
    import tms_pkg::*;

    // write channel holding registers
    logic [AW-1:0] aw_addr_reg;
    logic          aw_hold_reg;
    logic [7:0]    w_data_reg;
    logic          w_strb0_reg;
    logic          w_hold_reg;
    logic          bvalid_reg;
    logic [1:0]    bresp_reg;

    // read channel registers
    logic          rvalid_reg;
    logic [31:0]   rdata_reg;
    logic [1:0]    rresp_reg;

    // block registers
    logic [3:0]    run_reg;
    logic [3:0]    run_next;
    logic [7:0]    t0_ctrl_reg;
    logic [7:0]    reload_hi_reg;
    logic [7:0]    reload_lo_reg;
    logic [15:0]   count_reg;
    logic [15:0]   count_next;
    logic          status_reg;
    logic          status_next;
    logic          irq_mask_reg;
    logic          uf_reg;
    logic          uf_next;

    // dividers
    logic [$clog2(FAST_DIV)-1:0] fast_cnt_reg;
    logic [$clog2(SLOW_DIV)-1:0] slow_cnt_reg;
    logic          fast_tick;
    logic          slow_tick;

    // control fields
    wire tms_mode_t  t0_mode  = tms_mode_t'(t0_ctrl_reg[T0_MODE_LSB +: 2]);
    wire tms_clk_t   t0_clk   = tms_clk_t'(t0_ctrl_reg[T0_CLK_LSB +: 2]);
    wire logic       t0_auto  = t0_ctrl_reg[T0_AUTO];
    wire logic       t0_stop_rx = t0_ctrl_reg[T0_STOP_RX];
    wire logic       t0_trim  = (t0_mode == MODE_TRIM_HOLD) ||
                                (t0_mode == MODE_TRIM_WRAP);
    wire logic [15:0] reload_value = {reload_hi_reg, reload_lo_reg};

    // write decode
    wire logic       do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire logic [5:0] wr_idx   = aw_addr_reg[7:2];
    wire logic       wr_en    = do_write && w_strb0_reg;
    wire logic       wr_tsec  = wr_en && (wr_idx == IDX_TSEC_CTRL);
    wire logic       wr_t0c   = wr_en && (wr_idx == IDX_T0_CTRL);
    wire logic       wr_rhi   = wr_en && (wr_idx == IDX_T0_RELOAD_HI);
    wire logic       wr_rlo   = wr_en && (wr_idx == IDX_T0_RELOAD_LO);
    wire logic       wr_stat  = wr_en && (wr_idx == IDX_IRQ_STATUS);
    wire logic       wr_mask  = wr_en && (wr_idx == IDX_IRQ_MASK);
    wire logic       wr_known = (wr_idx == IDX_TSEC_CTRL) ||
                                (wr_idx == IDX_T0_CTRL) ||
                                (wr_idx == IDX_T0_RELOAD_HI) ||
                                (wr_idx == IDX_T0_RELOAD_LO) ||
                                (wr_idx == IDX_T0_COUNT_HI) ||
                                (wr_idx == IDX_T0_COUNT_LO) ||
                                (wr_idx == IDX_IRQ_STATUS) ||
                                (wr_idx == IDX_IRQ_MASK);
    wire logic [3:0] run_mask = w_data_reg[3:0];
    wire logic [3:0] run_val  = w_data_reg[RUN_LSB +: 4];

    // read decode
    wire logic       ar_take  = s_axi_arvalid && !rvalid_reg;
    wire logic [5:0] rd_idx   = s_axi_araddr[7:2];
    wire logic       rd_known = (rd_idx == IDX_TSEC_CTRL) ||
                                (rd_idx == IDX_T0_CTRL) ||
                                (rd_idx == IDX_T0_RELOAD_HI) ||
                                (rd_idx == IDX_T0_RELOAD_LO) ||
                                (rd_idx == IDX_T0_COUNT_HI) ||
                                (rd_idx == IDX_T0_COUNT_LO) ||
                                (rd_idx == IDX_IRQ_STATUS) ||
                                (rd_idx == IDX_IRQ_MASK);
    wire logic [7:0] rd_byte  =
        (rd_idx == IDX_TSEC_CTRL)    ? {run_reg, 4'h0} :
        (rd_idx == IDX_T0_CTRL)      ? t0_ctrl_reg :
        (rd_idx == IDX_T0_RELOAD_HI) ? reload_hi_reg :
        (rd_idx == IDX_T0_RELOAD_LO) ? reload_lo_reg :
        (rd_idx == IDX_T0_COUNT_HI)  ? count_reg[15:8] :
        (rd_idx == IDX_T0_COUNT_LO)  ? count_reg[7:0] :
        (rd_idx == IDX_IRQ_STATUS)   ? {7'h00, status_reg} :
        (rd_idx == IDX_IRQ_MASK)     ? {7'h00, irq_mask_reg} :
                                       8'h00;

    // tick selection
    wire logic tick =
        (t0_clk == CLK_FAST)   ? fast_tick :
        (t0_clk == CLK_SLOW)   ? slow_tick :
        (t0_clk == CLK_TIMER2) ? timer2_underflow :
                                 timer1_underflow;

    // bus handshakes
    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready  = !w_hold_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // outputs
    assign timer_run_flag   = run_reg[3:1];
    assign timer0_underflow = uf_reg;
    assign irq              = status_reg && irq_mask_reg;

    // clock dividers
    assign fast_tick = (fast_cnt_reg == '0);
    assign slow_tick = (slow_cnt_reg == '0);

    always_ff @(posedge aclk) begin
        if (!aresetn || fast_tick) begin
            fast_cnt_reg <= ($clog2(FAST_DIV))'(FAST_DIV - 1);
        end else begin
            fast_cnt_reg <= fast_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || slow_tick) begin
            slow_cnt_reg <= ($clog2(SLOW_DIV))'(SLOW_DIV - 1);
        end else begin
            slow_cnt_reg <= slow_cnt_reg - 1'b1;
        end
    end

    // timer0 and run flags
    always_comb begin
        run_next   = run_reg;
        count_next = count_reg;
        uf_next    = 1'b0;
        // other timers report their own stop
        run_next[3:1] = run_reg[3:1] & ~timer_stopped;
        if (run_reg[0] && tick) begin
            if (count_reg != '0) begin
                count_next = count_reg - 16'h0001;
            end else if (t0_mode != MODE_TRIM_HOLD) begin
                uf_next = 1'b1;
                if (t0_auto) begin
                    count_next = reload_value;
                end else begin
                    run_next[0] = 1'b0;
                end
            end
        end
        if (t0_mode == MODE_TX_END && tx_end) begin
            run_next[0] = 1'b1;
            count_next  = reload_value;
        end
        if (t0_trim && lfo_posedge) begin
            run_next[0] = !run_reg[0];
            if (!run_reg[0]) begin
                count_next = reload_value;
            end
        end
        if (t0_stop_rx && !t0_trim && rx_first_bits) begin
            run_next[0] = 1'b0;
        end
        if (wr_tsec) begin
            for (int i = 0; i < 4; i++) begin
                if (run_mask[i]) begin
                    run_next[i] = run_val[i];
                end
            end
            if (run_mask[0] && run_val[0]) begin
                count_next = reload_value;
            end
        end
    end

    // sticky underflow flag, set wins over clear
    assign status_next = (status_reg && !(wr_stat && w_data_reg[0]))
                         || uf_next;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_reg    <= 4'h0;
            count_reg  <= COUNT_RST;
            uf_reg     <= 1'b0;
            status_reg <= 1'b0;
        end else begin
            run_reg    <= run_next;
            count_reg  <= count_next;
            uf_reg     <= uf_next;
            status_reg <= status_next;
        end
    end

    // software registers, reload bytes only stored here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t0_ctrl_reg   <= T0_CTRL_RST;
            reload_hi_reg <= RELOAD_RST;
            reload_lo_reg <= RELOAD_RST;
            irq_mask_reg  <= 1'b0;
        end else begin
            if (wr_t0c) begin
                t0_ctrl_reg <= w_data_reg & T0_CTRL_WMASK;
            end
            if (wr_rhi) begin
                reload_hi_reg <= w_data_reg;
            end
            if (wr_rlo) begin
                reload_lo_reg <= w_data_reg;
            end
            if (wr_mask) begin
                irq_mask_reg <= w_data_reg[0];
            end
        end
    end

    // write address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_reg  <= 1'b0;
            w_data_reg  <= 8'h00;
            w_strb0_reg <= 1'b0;
        end else if (s_axi_wvalid && !w_hold_reg) begin
            w_hold_reg  <= 1'b1;
            w_data_reg  <= s_axi_wdata[7:0];
            w_strb0_reg <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_hold_reg <= 1'b0;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h000000, rd_byte};
            rresp_reg  <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

endmodule

// ===== tb/test_tms_timer_section.sv
`timescale 1ns/100ps
module test_tms_timer_section;
    import tms_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr, araddr, d;
    logic [31:0] wdata, rdata, rv;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, uf, irq;
    logic [1:0]  bresp, rresp, rr;
    logic [4:0]  ev;
    logic [3:1]  stopped, ts, run_flag;
    int          errors = 0, num_checks = 0, uf_cnt = 0, n, i, run;
    int          seed = 32'ha85ffdc6;
    logic [5:0]  regs[$] = '{6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13,
                             6'h20, 6'h21};

    tms_timer_section u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'b000), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_end(ev[0]),
        .rx_first_bits(ev[1]), .lfo_posedge(ev[2]),
        .timer1_underflow(ev[3]), .timer2_underflow(ev[4]),
        .timer_stopped(stopped), .timer_run_flag(run_flag),
        .timer0_underflow(uf), .irq(irq)
    );

    always #2.5 aclk = ~aclk;
    always @(posedge aclk) if (uf) uf_cnt <= uf_cnt + 1;

    task summarize;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task tmo(input int k);
        if (k >= 200) begin
            errors++;
            summarize();
        end
    endtask

    task wr(input logic [5:0] a, input logic [7:0] v,
            input logic [1:0] e = RESP_OKAY);
        @(posedge aclk);
        awaddr <= {a, 2'b00};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        tmo(n);
        chk({bresp, 32'h0}, {e, 32'h0});
    endtask

    task rdv(input logic [5:0] a);
        @(posedge aclk);
        araddr <= {a, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
        tmo(n);
    endtask

    task rd(input logic [5:0] a, input logic [7:0] e,
            input logic [1:0] s = RESP_OKAY);
        rdv(a);
        chk({rr, rv}, {s, 24'h0, e});
    endtask

    task pulse(input int b, input int k);
        repeat (k) begin
            @(posedge aclk);
            ev[b] <= 1'b1;
            @(posedge aclk);
            ev[b] <= 1'b0;
        end
    endtask

    task cnt(input logic [15:0] e);
        rd(IDX_T0_COUNT_HI, e[15:8]);
        rd(IDX_T0_COUNT_LO, e[7:0]);
    endtask

    task start(input logic [7:0] c, input logic [15:0] r);
        wr(IDX_T0_CTRL, c);
        wr(IDX_T0_RELOAD_HI, r[15:8]);
        wr(IDX_T0_RELOAD_LO, r[7:0]);
        wr(IDX_TSEC_CTRL, 8'h11);
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, ev, stopped} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[k]) rd(regs[k], 8'h00);
        rd(6'h3f, 8'h00, RESP_SLVERR);
        wr(6'h3f, 8'h01, RESP_SLVERR);
        wr(IDX_T0_CTRL, 8'hff);
        rd(IDX_T0_CTRL, T0_CTRL_WMASK);
        wr(IDX_T0_COUNT_LO, 8'h55);
        rd(IDX_T0_COUNT_LO, 8'h00);
        $display("test registers done");
        start(8'h09, 16'hffff);
        run = 1;
        for (i = 0; i < 10; i++) begin
            d = (i == 0) ? 8'hff : (i == 1) ? 8'hf0 : 8'($random(seed));
            run = (run & ~d[3:0]) | (d[7:4] & d[3:0]);
            wr(IDX_TSEC_CTRL, d);
            rd(IDX_TSEC_CTRL, 8'(run << 4));
            chk(34'(run_flag), 34'(run >> 1));
            ts = 3'($random(seed));
            @(posedge aclk);
            stopped <= ts;
            @(posedge aclk);
            stopped <= 3'b000;
            run = run & ~(int'(ts) << 1);
        end
        wr(IDX_TSEC_CTRL, 8'h0f);
        rd(IDX_TSEC_CTRL, 8'h00);
        $display("test run flags done");
        start(8'h0a, 16'h0110);
        cnt(16'h0110);
        pulse(4, 3);
        cnt(16'h010d);
        pulse(3, 2);
        cnt(16'h010d);
        wr(IDX_T0_CTRL, 8'h0b);
        pulse(3, 2);
        cnt(16'h010b);
        wr(IDX_T0_RELOAD_HI, 8'h22);
        cnt(16'h010b);
        wr(IDX_TSEC_CTRL, 8'h11);
        cnt(16'h2210);
        $display("test cascade done");
        wr(IDX_IRQ_MASK, 8'h01);
        start(8'h02, 16'h0001);
        pulse(4, 3);
        rd(IDX_TSEC_CTRL, 8'h00);
        rd(IDX_IRQ_STATUS, 8'h01);
        chk(34'(irq), 34'h1);
        cnt(16'h0000);
        wr(IDX_IRQ_STATUS, 8'h01);
        chk(34'(irq), 34'h0);
        start(8'h0a, 16'h0001);
        pulse(4, 2);
        cnt(16'h0001);
        rd(IDX_TSEC_CTRL, 8'h10);
        chk(34'(uf_cnt), 34'h2);
        wr(IDX_IRQ_STATUS, 8'h01);
        $display("test underflow done");
        start(8'h08, 16'h00ff);
        repeat (280) @(posedge aclk);
        rdv(IDX_T0_COUNT_LO);
        chk(34'(rv >= 32'hea && rv <= 32'hec), 34'h1);
        start(8'h09, 16'h00ff);
        repeat (2829) @(posedge aclk);
        rdv(IDX_T0_COUNT_LO);
        chk(34'(rv >= 32'hfb && rv <= 32'hfd), 34'h1);
        wr(IDX_TSEC_CTRL, 8'h01);
        $display("test clock rates done");
        wr(IDX_T0_CTRL, 8'h02);
        pulse(0, 1);
        rd(IDX_TSEC_CTRL, 8'h00);
        wr(IDX_T0_CTRL, 8'h12);
        pulse(0, 1);
        rd(IDX_TSEC_CTRL, 8'h10);
        pulse(1, 1);
        rd(IDX_TSEC_CTRL, 8'h10);
        wr(IDX_T0_CTRL, 8'h92);
        pulse(1, 1);
        rd(IDX_TSEC_CTRL, 8'h00);
        wr(IDX_T0_RELOAD_HI, 8'h00);
        wr(IDX_T0_RELOAD_LO, 8'h00);
        wr(IDX_T0_CTRL, 8'ha2);
        pulse(2, 1);
        pulse(1, 1);
        pulse(4, 3);
        rd(IDX_TSEC_CTRL, 8'h10);
        rd(IDX_IRQ_STATUS, 8'h00);
        pulse(2, 1);
        rd(IDX_TSEC_CTRL, 8'h00);
        wr(IDX_T0_CTRL, 8'hb2);
        pulse(2, 1);
        pulse(4, 1);
        rd(IDX_IRQ_STATUS, 8'h01);
        $display("test modes done");
        summarize();
    end
endmodule

// ===== tb/tms_timer_section_assertions.sv
`timescale 1ns/100ps
module tms_timer_section_assertions (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus responses
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // timer events
    input wire logic        timer1_underflow,
    input wire logic        timer2_underflow,
    input wire logic [3:1]  timer_stopped,
    input wire logic [3:1]  timer_run_flag,
    input wire logic        timer0_underflow,
    input wire logic        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    resp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    read_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    byte_only_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    flag_cause_a: assert property (
        !$stable(timer_run_flag) |-> $rose(s_axi_bvalid) || $past(|timer_stopped))
        else $error("run flag changed without cause");
    stop_clears_a: assert property (
        !$rose(s_axi_bvalid) |-> ($past(timer_stopped) & timer_run_flag) == 3'b000)
        else $error("stopped timer still flagged");
    under_pulse_a: assert property (
        timer0_underflow && !timer1_underflow && !timer2_underflow
        |=> !timer0_underflow) else $error("underflow pulse too long");
    irq_rise_a: assert property (
        $rose(irq) && !$rose(s_axi_bvalid) |-> ##[0:1] timer0_underflow)
        else $error("interrupt without underflow");
    irq_fall_a: assert property (
        $fell(irq) |-> $rose(s_axi_bvalid))
        else $error("interrupt cleared without write");

    cover property (timer0_underflow);
    cover property ($fell(irq));
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind tms_timer_section tms_timer_section_assertions u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer1_underflow(timer1_underflow),
    .timer2_underflow(timer2_underflow), .timer_stopped(timer_stopped),
    .timer_run_flag(timer_run_flag), .timer0_underflow(timer0_underflow),
    .irq(irq)
);
